/* File: pkg/sram_ctrl_pkg.sv */
// shared constants and carrier structs for the burst memory control block
package sram_ctrl_pkg;

  // =====================================================
  // widths and fixed values
  localparam int ADDR_W     = 21;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int DATA_W     = LANES * LANE_W;
  localparam int BURST_W    = 2;
  localparam int FIFO_DEPTH = 4;
  localparam logic [1:0] BURST_RESET = 2'h0;
  localparam logic [3:0] LANES_NONE  = 4'h0;
  localparam logic [3:0] LANES_ALL   = 4'hf;

  // =====================================================
  // synchronous control pins as one bundle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              select_low_first;
    logic              select_high_second;
    logic              select_low_third;
    logic              cpu_address_strobe_n;
    logic              cache_ctrl_address_strobe_n;
    logic              advance_n;
    logic              lane_a_write_select_n;
    logic              lane_b_write_select_n;
    logic              lane_c_write_select_n;
    logic              lane_d_write_select_n;
    logic              byte_write_qualifier_n;
    logic              all_lanes_write_n;
  } ctrl_pins_s;

  // one write toward the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] data;
  } wr_req_s;

endpackage

/* File: hdl/wr_fifo.sv */
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } fifo_state_s;

  fifo_state_s state_reg;
  fifo_state_s state_next;
  logic        push;
  logic        pop;

  // full and empty come straight from the registered count
  assign in_ready  = (state_reg.count != (PW+1)'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data  = state_reg.mem[state_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer wrap relies on depth being a power of two
  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = in_data;
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
    state_next.count = state_reg.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge core_clk) disable iff (rst)
    state_reg.count <= (PW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

`default_nettype wire

/* File: hdl/sync_burst_sram_control.sv */
// control logic of a synchronous pipelined burst memory, memory side
// What this block does
// [R1] all synchronous inputs are registered on the rising clock edge
// [R2] burst counter advances on each edge with advance sampled low
// [R3] without global write, a lane writes only when its select and the byte qualifier are low
// [R4] global write low writes every lane, ignoring selects and qualifier
// [R5] selected means first select low, second high, third low
// [R6] processor strobe ignored when first select is high
// [R7] chip selects only examined when a new external address loads
// [R8] output enable low drives read data, high makes pins inputs
// [R9] first read clock after deselect keeps outputs off
// [R10] processor strobe low captures address and seeds burst counter
// [R11] controller strobe low likewise captures address and seeds counter
// [R12] both strobes low: only the processor strobe counts
// [R13] two-bit burst counter seeded from two lowest address bits
// [R14] deselected: no write and data pins stay undriven
// [R15] master holds advance high to repeat the current burst address
`timescale 1ns/10ps
`default_nettype none

module sync_burst_sram_control (
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  input  wire sram_ctrl_pkg::ctrl_pins_s         pins,
  input  wire logic                              output_enable_n,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0]  rd_data,
  output logic [sram_ctrl_pkg::ADDR_W-1:0]       array_addr,
  output logic                                   array_rd,
  output sram_ctrl_pkg::wr_req_s                 wr_req,
  output logic                                   wr_valid,
  input  wire logic                              wr_ready,
  output logic [sram_ctrl_pkg::DATA_W-1:0]       dq_out,
  output logic                                   dq_oe_n,
  output logic                                   pins_ready
);

  // =====================================================
  // state
  typedef struct packed {
    sram_ctrl_pkg::ctrl_pins_s      pin_q;
    logic [sram_ctrl_pkg::ADDR_W-1:0] base_addr;
    logic [1:0]                     burst_cnt;
    logic                           selected;
    logic                           first_read;
    logic                           read_live;
    logic [sram_ctrl_pkg::ADDR_W-1:0] array_addr;
    logic                           array_rd;
    logic [sram_ctrl_pkg::DATA_W-1:0] dq_out;
    logic                           drive_ok;
    logic                           dq_oe_n;
    // output enable is asynchronous, so it passes two flops first
    logic                           oe_meta;
    logic                           oe_sync;
  } ctl_state_s;

  ctl_state_s             state_reg;
  ctl_state_s             state_next;
  sram_ctrl_pkg::wr_req_s fifo_in;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic                   load_cpu;
  logic                   load_ctrl;
  logic                   load;
  logic                   sel_now;
  logic                   is_write;
  logic [3:0]             lanes;

  // decode of the three selects, used only when an address loads
  function automatic logic chip_selected(input sram_ctrl_pkg::ctrl_pins_s p);
    chip_selected = !p.select_low_first && p.select_high_second
                    && !p.select_low_third; // R5
  endfunction

  // lanes enabled by global write or qualified byte selects
  function automatic logic [3:0] lane_mask(input sram_ctrl_pkg::ctrl_pins_s p);
    logic [3:0] sel;
    sel = ~{p.lane_d_write_select_n, p.lane_c_write_select_n,
            p.lane_b_write_select_n, p.lane_a_write_select_n};
    if (!p.all_lanes_write_n) begin
      lane_mask = sram_ctrl_pkg::LANES_ALL; // R4
    end else if (!p.byte_write_qualifier_n) begin
      lane_mask = sel; // R3
    end else begin
      lane_mask = sram_ctrl_pkg::LANES_NONE;
    end
  endfunction

  // =====================================================
  // decode of the registered pin sample
  // strobe decode acts on the previous edge's capture, so a load takes
  // effect one cycle after the pins, a fixed and predictable latency
  always_comb begin
    load_cpu  = !state_reg.pin_q.cpu_address_strobe_n
                && !state_reg.pin_q.select_low_first; // R6 R10
    load_ctrl = !state_reg.pin_q.cache_ctrl_address_strobe_n
                && !load_cpu
                && state_reg.pin_q.cpu_address_strobe_n; // R11 R12
    load      = load_cpu || load_ctrl;
    // selects only re-evaluated when an address loads
    sel_now   = load ? chip_selected(state_reg.pin_q)
                     : state_reg.selected; // R7
    lanes     = lane_mask(state_reg.pin_q);
    is_write  = (lanes != sram_ctrl_pkg::LANES_NONE);
  end

  // =====================================================
  // next state
  always_comb begin
    logic [1:0]                     cnt;
    logic [sram_ctrl_pkg::ADDR_W-1:0] base;
    cnt  = state_reg.burst_cnt;
    base = state_reg.base_addr;
    state_next = state_reg;
    fifo_in    = '0;
    fifo_in_valid = 1'b0;
    // hold the pin sample while the write fifo is full, stalling master
    if (fifo_in_ready) begin
      state_next.pin_q = pins; // R1
    end
    if (load) begin
      base = state_reg.pin_q.addr;                       // R10 R11
      cnt  = state_reg.pin_q.addr[sram_ctrl_pkg::BURST_W-1:0]; // R13
    end else if (!state_reg.pin_q.advance_n) begin
      cnt  = state_reg.burst_cnt + 2'h1; // R2
    end
    // advance high leaves the counter alone R15
    state_next.base_addr = base;
    state_next.burst_cnt = cnt;
    state_next.selected  = sel_now;
    state_next.array_addr = {base[sram_ctrl_pkg::ADDR_W-1:
                                  sram_ctrl_pkg::BURST_W], cnt};
    // write only when selected and the fifo can take it
    if (sel_now && is_write && fifo_in_ready) begin
      fifo_in.addr  = {base[sram_ctrl_pkg::ADDR_W-1:sram_ctrl_pkg::BURST_W],
                       cnt};
      fifo_in.lanes = lanes; // R3 R4
      fifo_in.data  = state_reg.pin_q.wdata;
      fifo_in_valid = 1'b1; // R14
    end
    state_next.array_rd   = sel_now && !is_write;
    state_next.first_read = sel_now && !is_write && !state_reg.selected; // R9
    state_next.read_live  = sel_now && !is_write;
    state_next.dq_out     = rd_data;
    // drive permitted only for a live read that is not the first after
    // deselect; the pin enable itself follows output enable below
    state_next.drive_ok   = state_reg.read_live && !state_reg.first_read;
    // only the second flop is read, so a late edge adds a cycle at most
    state_next.oe_meta    = output_enable_n;
    state_next.oe_sync    = state_reg.oe_meta;
    state_next.dq_oe_n    = !(state_next.drive_ok
                              && !state_reg.oe_sync); // R8 R9 R14
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.pin_q.select_low_first <= 1'b1;
      state_reg.pin_q.cpu_address_strobe_n <= 1'b1;
      state_reg.pin_q.cache_ctrl_address_strobe_n <= 1'b1;
      state_reg.pin_q.advance_n <= 1'b1;
      state_reg.pin_q.all_lanes_write_n <= 1'b1;
      state_reg.pin_q.byte_write_qualifier_n <= 1'b1;
      state_reg.burst_cnt <= sram_ctrl_pkg::BURST_RESET;
      state_reg.dq_oe_n <= 1'b1;
      state_reg.oe_meta <= 1'b1;
      state_reg.oe_sync <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================
  // write buffer toward the array
  wr_fifo #(
    .WIDTH ($bits(sram_ctrl_pkg::wr_req_s)),
    .DEPTH (sram_ctrl_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (wr_req),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );

  assign array_addr = state_reg.array_addr;
  assign array_rd   = state_reg.array_rd;
  assign dq_out     = state_reg.dq_out;
  assign dq_oe_n    = state_reg.dq_oe_n;
  assign pins_ready = fifo_in_ready;

  // =====================================================
  // checks
  sequence s_adv_low;
    !load && !state_reg.pin_q.advance_n;
  endsequence

  a_burst_advance: assert property (@(posedge core_clk) disable iff (rst)
    s_adv_low |=> state_reg.burst_cnt == $past(state_reg.burst_cnt) + 2'h1) // R2
    else $error("burst counter did not advance");

  a_burst_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!load && state_reg.pin_q.advance_n) |=> $stable(state_reg.burst_cnt)) // R15
    else $error("burst counter moved while advance high");

  a_seed_counter: assert property (@(posedge core_clk) disable iff (rst)
    load |=> state_reg.burst_cnt == $past(state_reg.pin_q.addr[1:0])) // R13
    else $error("burst counter not seeded");

  a_cpu_priority: assert property (@(posedge core_clk) disable iff (rst)
    (load_cpu |-> !load_ctrl)) // R12
    else $error("controller strobe taken with processor strobe");

  a_cpu_gated: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg.pin_q.select_low_first && state_reg.pin_q.advance_n
     && state_reg.pin_q.cache_ctrl_address_strobe_n)
    |=> $stable(state_reg.base_addr)) // R6
    else $error("processor strobe taken with first select high");

  a_select_hold: assert property (@(posedge core_clk) disable iff (rst)
    !load |=> state_reg.selected == $past(state_reg.selected)) // R7
    else $error("selects re-examined without a load");

  a_no_write_desel: assert property (@(posedge core_clk) disable iff (rst)
    !sel_now |-> !fifo_in_valid) // R14
    else $error("write while deselected");

  a_global_write: assert property (@(posedge core_clk) disable iff (rst)
    (fifo_in_valid && !state_reg.pin_q.all_lanes_write_n)
    |-> fifo_in.lanes == sram_ctrl_pkg::LANES_ALL) // R4
    else $error("global write missed a lane");

  a_first_read_off: assert property (@(posedge core_clk) disable iff (rst)
    state_reg.first_read |=> dq_oe_n) // R9
    else $error("output driven on first read after deselect");

  a_oe_high_off: assert property (@(posedge core_clk) disable iff (rst)
    state_reg.oe_sync |=> dq_oe_n) // R8
    else $error("data driven with output enable high");
endmodule

`default_nettype wire

/* File: test/sram_array_model.sv */
// behavioural memory array behind the control block, with stallable writes
`timescale 1ns/10ps
`default_nettype none

module sram_array_model (
  input  wire logic                             core_clk,
  input  wire logic                             stall,
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] array_addr,
  input  wire sram_ctrl_pkg::wr_req_s           wr_req,
  input  wire logic                             wr_valid,
  output logic                                  wr_ready,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      rd_data
);
  logic [sram_ctrl_pkg::DATA_W-1:0] mem [16];

  // =====================================================
  // only 16 words are kept, so upper address bits alias
  assign rd_data  = mem[array_addr[3:0]];
  assign wr_ready = ~stall;

  // merge only the enabled lanes into the word
  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) begin
      for (int k = 0; k < sram_ctrl_pkg::LANES; k++) begin
        if (wr_req.lanes[k]) begin
          mem[wr_req.addr[3:0]][k*9 +: 9] <= wr_req.data[k*9 +: 9];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/sync_burst_sram_control_tb_top.sv */
// self-checking bench for the burst memory control block
`timescale 1ns/10ps
`default_nettype none

module sync_burst_sram_control_tb_top;
  logic                      core_clk = 1'h0;
  logic                      rst = 1'h1;
  logic                      output_enable_n = 1'h1;
  logic                      stall = 1'h0;
  logic                      stall_hi = 1'h0;
  logic                      saw_full = 1'h0;
  sram_ctrl_pkg::ctrl_pins_s pins, p, idle;
  sram_ctrl_pkg::wr_req_s    wr_req, e, wq[$];
  logic [20:0]               array_addr, base, rq[$];
  logic [35:0]               rd_data, dq_out, d;
  logic [1:0]                cnt;
  logic [3:0]                ln;
  logic                      array_rd, wr_valid, wr_ready, dq_oe_n;
  logic                      pins_ready;
  int                        n_errors = 0;
  int                        cmp_count = 0;

  always #5 core_clk = ~core_clk;

  sync_burst_sram_control dut (.core_clk(core_clk), .rst(rst), .pins(pins),
    .output_enable_n(output_enable_n), .rd_data(rd_data),
    .array_addr(array_addr), .array_rd(array_rd), .wr_req(wr_req),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .pins_ready(pins_ready));

  sram_array_model mem_u (.core_clk(core_clk), .stall(stall),
    .array_addr(array_addr), .wr_req(wr_req), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data));

  // =====================================================
  // comparison and verdict
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // =====================================================
  // stimulus helpers: sel starts a selected load, go notes and drives
  task automatic sel(input logic [20:0] a);
    p = idle;
    p.select_low_first = 1'h0;
    p.all_lanes_write_n = 1'h1;
    p.addr = a;
    p.wdata = 36'({$urandom, $urandom});
    base = a;
    cnt = a[1:0];
  endtask

  // pins are held while the block is full; stall then frees up randomly
  task automatic go(input int what, input logic [3:0] lanes);
    if (what == 1) rq.push_back({base[20:2], cnt});
    if (what == 2) wq.push_back({base[20:2], cnt, lanes, p.wdata});
    @(negedge core_clk);
    pins = p;
    stall = stall_hi | ($urandom_range(3) == 0);
    for (int i = 0; i < 200 && !pins_ready; i++) begin
      @(negedge core_clk);
      stall = 1'($urandom_range(1));
    end
  endtask

  task automatic drain;
    stall_hi = 1'h0;
    for (int i = 0; i < 64 && wr_valid; i++) begin
      @(negedge core_clk);
      stall = 1'h0;
    end
  endtask

  // =====================================================
  // monitor: every array read or accepted write takes the oldest note
  always @(posedge core_clk) begin
    if (!pins_ready) saw_full = 1'h1;
    if (array_rd) check(array_addr, rq.size() ? rq.pop_front() : 'x);
    if (wr_valid && wr_ready) begin
      e = wq.size() ? wq.pop_front() : 'x;
      check({wr_req.addr, wr_req.lanes}, {e.addr, e.lanes});
      if (e.lanes === 4'hf) check(wr_req.data, e.data);
    end
  end

  initial begin
    #200000;
    n_errors++;
    tally_and_finish;
  end

  // =====================================================
  // main sequence; idle is a controller-strobe deselect with write low
  initial begin
    void'($urandom(32'h5005));
    idle = '1;
    idle.cache_ctrl_address_strobe_n = 1'h0;
    idle.select_low_third = 1'h0;
    idle.all_lanes_write_n = 1'h0;
    pins = idle;
    p = idle;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'h0;
    check({dq_oe_n, wr_valid, pins_ready}, 3'h5);
    // every select combination; only low-high-low may write
    for (int i = 0; i < 8; i++) begin
      sel(21'($urandom));
      {p.select_low_first, p.select_high_second, p.select_low_third} = 3'(i);
      p.all_lanes_write_n = 1'h0;
      go(i == 2 ? 2 : 0, 4'hf);
      p = idle;
      go(0, 4'h0);
    end
    // byte writes; without the qualifier the same cycle is a read
    for (int i = 0; i < 8; i++) begin
      ln = 4'($urandom_range(15, 1));
      sel(21'($urandom));
      p.byte_write_qualifier_n = i[0];
      {p.lane_d_write_select_n, p.lane_c_write_select_n,
       p.lane_b_write_select_n, p.lane_a_write_select_n} = ~ln;
      go(i[0] ? 1 : 2, ln);
      p = idle;
      go(0, 4'h0);
    end
    // both strobes low, then a wrapping burst with selects gone bad
    sel(21'($urandom));
    p.cpu_address_strobe_n = 1'h0;
    go(1, 4'h0);
    p.cpu_address_strobe_n = 1'h1;
    p.cache_ctrl_address_strobe_n = 1'h1;
    p.select_high_second = 1'h0;
    p.advance_n = 1'h0;
    for (int i = 0; i < 4; i++) begin
      cnt++;
      go(1, 4'h0);
    end
    p.advance_n = 1'h1;
    go(1, 4'h0);
    // processor strobe with first select high loads nothing: the burst
    // address is simply repeated, as with advance high
    p.addr = 21'($urandom);
    p.cpu_address_strobe_n = 1'h0;
    p.cache_ctrl_address_strobe_n = 1'h1;
    p.select_low_first = 1'h1;
    go(1, 4'h0);
    p = idle;
    go(0, 4'h0);
    // write a word, then read it twice coming out of deselect
    sel(21'($urandom));
    p.all_lanes_write_n = 1'h0;
    d = p.wdata;
    go(2, 4'hf);
    p = idle;
    go(0, 4'h0);
    drain;
    output_enable_n = 1'h0;
    sel(base);
    go(1, 4'h0);
    p.cache_ctrl_address_strobe_n = 1'h1;
    go(1, 4'h0);
    p = idle;
    go(0, 4'h0);
    @(posedge core_clk) #1;
    check(dq_oe_n, 1'h1);
    @(posedge core_clk) #1;
    check({dq_oe_n, dq_out}, {1'h0, d});
    @(negedge core_clk);
    output_enable_n = 1'h1;
    repeat (3) @(negedge core_clk);
    check(dq_oe_n, 1'h1);
    // fill the write buffer against a stalled array, then drain it
    stall_hi = 1'h1;
    for (int i = 0; i < 6; i++) begin
      sel(21'($urandom));
      p.all_lanes_write_n = 1'h0;
      go(2, 4'hf);
    end
    p = idle;
    go(0, 4'h0);
    drain;
    repeat (6) @(negedge core_clk);
    check(saw_full, 1'h1);
    check(rq.size() + wq.size(), 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
